// ---- logic/pcfg_top.sv ----
// port pin-function, clock, loopback and polarity configuration with apb slave
//
// Behaviour
// - rx clock pin shows recovered clock when set, else gapped/overhead/low
// - rx shared pin carries frame start when set, data enable when clear
// - rx fractional port pins active only when enable bit set
// - tx clock pin shows tx output clock when set, else gapped/overhead
// - tx shared pin carries frame start when set, data enable when clear
// - tx fractional port pins active only when enable bit set
// - two-bit field picks local 8 kHz source; exported as global candidate
// - trailer and timer reference: global when clear, port source when set
// - loop timing takes tx clock from receive side, ignores tx clock pin
// - clock adapter allowed when clear; when set, pin used without loopback
// - rx framer pins timed from input clocks when set, output clocks when clear
// - tx framer pins timed from input clocks when set, output clocks when clear
// - tx line pins timed from input clocks when set, output clocks when clear
// - system bus loopback returns tx system traffic to rx through fifos
// - three-bit loopback mode field; reset value means no loopback
// - four-bit select for alarm on second gpio, only when pin enabled
// - four-bit select for alarm on first gpio, only when pin enabled
// - transmit invert bits flip polarity of their transmit pins
// - receive invert bits flip polarity of their receive pins
`timescale 1ns/1ps
`default_nettype none
module pcfg_top
  import pcfg_pkg::*;
#(
  parameter int ALARM_COUNT = 16
) (
  input wire logic MCLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // core-side transmit outputs and pin-side transmit inputs
  input wire pcfg_txpins_type TX_CORE,
  input wire pcfg_txpins_type TX_PIN_IN,
  output pcfg_txpins_type TX_PIN_OUT,
  output pcfg_txpins_type TX_CORE_IN,
  // core-side receive outputs and pin-side receive inputs
  input wire pcfg_rxpins_type RX_CORE,
  input wire pcfg_rxpins_type RX_PIN_IN,
  output pcfg_rxpins_type RX_PIN_OUT,
  output pcfg_rxpins_type RX_CORE_IN,
  // core clock candidates for the shared clock pins
  input wire logic RX_RECOV_OUT_CLK,
  input wire logic RX_GAPPED_CLK,
  input wire logic RX_OVERHEAD_CLK,
  input wire logic RX_OVERHEAD_MODE,
  input wire logic TX_OUT_CLK,
  input wire logic TX_GAPPED_CLK,
  input wire logic TX_OVERHEAD_CLK,
  input wire logic TX_OVERHEAD_MODE,
  // frame-start and data-enable candidates
  input wire logic RX_SOF,
  input wire logic RX_DEN,
  input wire logic TX_SOF,
  input wire logic TX_DEN,
  // clocks for tx clock selection
  input wire logic LIU_RECOV_CLK,
  input wire logic CLOCK_RATE_ADAPTER_CLK,
  input wire logic LIU_ENABLED,
  // 8 kHz reference sources
  input wire logic [3:0] LOCAL_REF_8K,
  input wire logic GLOBAL_REF_8K,
  // alarm routing
  input wire logic [ALARM_COUNT-1:0] ALARM_STATUS,
  input wire logic GPIO_A_OUT_EN,
  input wire logic GPIO_B_OUT_EN,
  // control outputs
  output logic RX_FRAC_PORT_EN,
  output logic TX_FRAC_PORT_EN,
  output logic PORT_REF_8K,
  output logic TIMER_REF_8K,
  output logic TX_CLOCK_INT,
  output logic [3:0] TX_CLOCK_SRC,
  output logic RX_FRAMER_INPUT_TIMED,
  output logic TX_FRAMER_INPUT_TIMED,
  output logic TX_LINE_INPUT_TIMED,
  output logic SYS_LOOPBACK_EN,
  output logic [2:0] LOOPBACK_MODE,
  output logic LOOPBACK_ACTIVE,
  output logic GPIO_A_OUT,
  output logic GPIO_B_OUT
);

  initial begin
    if (ALARM_COUNT < 1 || ALARM_COUNT > 16) $error("pcfg_top: alarm count must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode and registers

  logic [15:0] ctrl_reg;
  logic [15:0] loop_reg;
  logic [15:0] tinv_reg;
  logic [15:0] rinv_reg;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [15:0] rd_data_next;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;

  // offsets are register indices; each register owns one word, so the byte address is four times the index
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    return a == {ofs[9:0], 2'b00};
  endfunction

  assign wr_en = PSEL && PENABLE && PWRITE && pready_reg;
  assign rd_en = PSEL && PENABLE && !PWRITE && pready_reg;

  // one wait state: data registered in the first access cycle, ready in the next
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      pready_reg <= 1'b0;
    end else if (PSEL && PENABLE && !pready_reg) begin
      pready_reg <= 1'b1;
    end else begin
      pready_reg <= 1'b0;
    end
  end

  always_comb begin
    addr_hit = 1'b1;
    rd_data_next = 16'h0000;
    if (addr_is(PADDR, PCFG_OFS_CTRL)) begin
      rd_data_next = ctrl_reg;
    end else if (addr_is(PADDR, PCFG_OFS_LOOP)) begin
      rd_data_next = loop_reg;
    end else if (addr_is(PADDR, PCFG_OFS_TINV)) begin
      rd_data_next = tinv_reg;
    end else if (addr_is(PADDR, PCFG_OFS_RINV)) begin
      rd_data_next = rinv_reg;
    end else if (addr_is(PADDR, PCFG_OFS_STAT)) begin
      rd_data_next = {11'h000, LOOPBACK_ACTIVE, TX_CLOCK_SRC};
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (PSEL && PENABLE && !pready_reg) begin
      prdata_reg <= PWRITE ? 32'h0000_0000 : {16'h0000, rd_data_next};
      // status word is read-only; writes there and unmapped addresses flag an error
      pslverr_reg <= !addr_hit || (PWRITE && addr_is(PADDR, PCFG_OFS_STAT));
    end
  end

  assign PREADY = pready_reg;
  assign PRDATA = pready_reg ? prdata_reg : 32'h0000_0000;
  assign PSLVERR = pready_reg && pslverr_reg;

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ctrl_reg <= PCFG_RST_CTRL;
    end else if (wr_en && addr_is(PADDR, PCFG_OFS_CTRL)) begin
      ctrl_reg <= PWDATA[15:0] & PCFG_MASK_CTRL;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      loop_reg <= PCFG_RST_LOOP;
    end else if (wr_en && addr_is(PADDR, PCFG_OFS_LOOP)) begin
      loop_reg <= PWDATA[15:0] & PCFG_MASK_LOOP;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tinv_reg <= PCFG_RST_TINV;
    end else if (wr_en && addr_is(PADDR, PCFG_OFS_TINV)) begin
      tinv_reg <= PWDATA[15:0] & PCFG_MASK_TINV;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rinv_reg <= PCFG_RST_RINV;
    end else if (wr_en && addr_is(PADDR, PCFG_OFS_RINV)) begin
      rinv_reg <= PWDATA[15:0] & PCFG_MASK_RINV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function multiplexing

  logic rx_clk_core;
  logic rx_sof_core;
  logic tx_clk_core;
  logic tx_sof_core;
  pcfg_txpins_type tx_out_core;
  pcfg_rxpins_type rx_out_core;

  always_comb begin
    if (ctrl_reg[PCFG_B_RXCLK]) begin
      rx_clk_core = RX_RECOV_OUT_CLK;
    end else if (!ctrl_reg[PCFG_B_RXFPE]) begin
      rx_clk_core = RX_OVERHEAD_MODE ? RX_OVERHEAD_CLK : 1'b0;
    end else begin
      rx_clk_core = RX_GAPPED_CLK;
    end
  end

  assign rx_sof_core = ctrl_reg[PCFG_B_RXSOF] ? RX_SOF : RX_DEN;
  assign tx_clk_core = ctrl_reg[PCFG_B_TXCLK] ? TX_OUT_CLK :
    (TX_OVERHEAD_MODE ? TX_OVERHEAD_CLK : TX_GAPPED_CLK);
  assign tx_sof_core = ctrl_reg[PCFG_B_TXSOF] ? TX_SOF : TX_DEN;
  assign RX_FRAC_PORT_EN = ctrl_reg[PCFG_B_RXFPE];
  assign TX_FRAC_PORT_EN = ctrl_reg[PCFG_B_TXFPE];

  always_comb begin
    tx_out_core = TX_CORE;
    tx_out_core.clk_out = tx_clk_core;
    tx_out_core.sof_den_out = tx_sof_core;
    // disabled fractional port outputs rest low
    tx_out_core.pdat_en_out = TX_CORE.pdat_en_out & ctrl_reg[PCFG_B_TXFPE];
    rx_out_core = RX_CORE;
    rx_out_core.clk_out = rx_clk_core;
    rx_out_core.sof_den_out = rx_sof_core;
    rx_out_core.pdat = RX_CORE.pdat & ctrl_reg[PCFG_B_RXFPE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // polarity inversion at the pins

  pcfg_txpins_type tx_core_in_raw;

  pcfg_invert #(.WIDTH(16)) u_tx_out_inv (
    .mask(tinv_reg),
    .din(tx_out_core),
    .dout(TX_PIN_OUT)
  );

  pcfg_invert #(.WIDTH(16)) u_tx_in_inv (
    .mask(tinv_reg),
    .din(TX_PIN_IN),
    .dout(tx_core_in_raw)
  );

  pcfg_invert #(.WIDTH(16)) u_rx_out_inv (
    .mask(rinv_reg),
    .din(rx_out_core),
    .dout(RX_PIN_OUT)
  );

  pcfg_invert #(.WIDTH(16)) u_rx_in_inv (
    .mask(rinv_reg),
    .din(RX_PIN_IN),
    .dout(RX_CORE_IN)
  );

  // disabled fractional inputs are held inactive so stray pin levels do nothing
  always_comb begin
    TX_CORE_IN = tx_core_in_raw;
    TX_CORE_IN.pdat = tx_core_in_raw.pdat & ctrl_reg[PCFG_B_TXFPE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // 8 kHz reference and transmit clock selection

  assign PORT_REF_8K = LOCAL_REF_8K[ctrl_reg[PCFG_B_REFSH +: 2]];
  assign TIMER_REF_8K = ctrl_reg[PCFG_B_REFLOC] ? PORT_REF_8K : GLOBAL_REF_8K;

  pcfg_txsrc_type tx_src;
  logic line_lb;

  assign line_lb = (loop_reg[PCFG_B_LBMSH +: 3] != PCFG_LBM_NONE);

  // loop timing beats the adapter; adapter beats the input pin unless disabled
  always_comb begin
    tx_src = PCFG_TXS_PIN;
    if (ctrl_reg[PCFG_B_LOOP_TIMING_ENABLE] || line_lb) begin
      tx_src = LIU_ENABLED ? PCFG_TXS_RECOV : PCFG_TXS_LINE;
    end else if (!ctrl_reg[PCFG_B_CLOCK_ADAPTER_DISABLE]) begin
      tx_src = PCFG_TXS_CLOCK_RATE_ADAPTER;
    end
  end

  always_comb begin
    case (tx_src)
      PCFG_TXS_LINE: TX_CLOCK_INT = RX_CORE_IN.line_clk;
      PCFG_TXS_RECOV: TX_CLOCK_INT = LIU_RECOV_CLK;
      PCFG_TXS_CLOCK_RATE_ADAPTER: TX_CLOCK_INT = CLOCK_RATE_ADAPTER_CLK;
      default: TX_CLOCK_INT = TX_CORE_IN.clk_in;
    endcase
  end

  assign TX_CLOCK_SRC = tx_src;

  ////////////////////////////////////////////////////////////////////////////
  // timing references, loopback and alarm routing

  assign RX_FRAMER_INPUT_TIMED = ctrl_reg[PCFG_B_RX_FRAMER_TIMING_SELECT];
  assign TX_FRAMER_INPUT_TIMED = ctrl_reg[PCFG_B_TX_FRAMER_TIMING_SELECT];
  assign TX_LINE_INPUT_TIMED = ctrl_reg[PCFG_B_TX_LINE_TIMING_SELECT];
  assign SYS_LOOPBACK_EN = loop_reg[PCFG_B_SYSLB];
  assign LOOPBACK_MODE = loop_reg[PCFG_B_LBMSH +: 3];
  assign LOOPBACK_ACTIVE = line_lb || loop_reg[PCFG_B_SYSLB];

  logic [15:0] alarm_ext;
  logic gpio_a_reg;
  logic gpio_b_reg;

  // codes beyond the wired alarm count read as inactive
  assign alarm_ext = 16'(ALARM_STATUS);

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      gpio_a_reg <= 1'b0;
    end else begin
      gpio_a_reg <= GPIO_A_OUT_EN & alarm_ext[loop_reg[PCFG_B_GPASH +: 4]];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      gpio_b_reg <= 1'b0;
    end else begin
      gpio_b_reg <= GPIO_B_OUT_EN & alarm_ext[loop_reg[PCFG_B_GPBSH +: 4]];
    end
  end

  assign GPIO_A_OUT = gpio_a_reg;
  assign GPIO_B_OUT = gpio_b_reg;

endmodule
`default_nettype wire

// ---- shared/pcfg_pkg.sv ----
// package: register map, field positions and pin bundles for the port pin/clock configuration block
package pcfg_pkg;

  localparam logic [11:0] PCFG_OFS_CTRL = 12'h044;
  localparam logic [11:0] PCFG_OFS_LOOP = 12'h046;
  localparam logic [11:0] PCFG_OFS_TINV = 12'h04a;
  localparam logic [11:0] PCFG_OFS_RINV = 12'h04c;
  localparam logic [11:0] PCFG_OFS_STAT = 12'h050;

  localparam logic [15:0] PCFG_RST_CTRL = 16'h0000;
  localparam logic [15:0] PCFG_RST_LOOP = 16'h0000;
  localparam logic [15:0] PCFG_RST_TINV = 16'h0000;
  localparam logic [15:0] PCFG_RST_RINV = 16'h0000;

  localparam logic [15:0] PCFG_MASK_CTRL = 16'h3fff;
  localparam logic [15:0] PCFG_MASK_LOOP = 16'h0fff;
  localparam logic [15:0] PCFG_MASK_TINV = 16'hdfff;
  localparam logic [15:0] PCFG_MASK_RINV = 16'h76de;

  localparam int PCFG_B_RXCLK = 13;
  localparam int PCFG_B_RXSOF = 12;
  localparam int PCFG_B_RXFPE = 11;
  localparam int PCFG_B_TXCLK = 10;
  localparam int PCFG_B_TXSOF = 9;
  localparam int PCFG_B_TXFPE = 8;
  localparam int PCFG_B_REFSH = 6;
  localparam int PCFG_B_REFLOC = 5;
  localparam int PCFG_B_LOOP_TIMING_ENABLE = 4;
  localparam int PCFG_B_CLOCK_ADAPTER_DISABLE = 3;
  localparam int PCFG_B_RX_FRAMER_TIMING_SELECT = 2;
  localparam int PCFG_B_TX_FRAMER_TIMING_SELECT = 1;
  localparam int PCFG_B_TX_LINE_TIMING_SELECT = 0;
  localparam int PCFG_B_SYSLB = 11;
  localparam int PCFG_B_LBMSH = 8;
  localparam int PCFG_B_GPBSH = 4;
  localparam int PCFG_B_GPASH = 0;

  localparam logic [2:0] PCFG_LBM_NONE = 3'h0;

  // transmit tx clock source choice, one-hot
  typedef enum logic [3:0] {
    PCFG_TXS_PIN   = 4'b0001,
    PCFG_TXS_LINE  = 4'b0010,
    PCFG_TXS_CLOCK_RATE_ADAPTER  = 4'b0100,
    PCFG_TXS_RECOV = 4'b1000
  } pcfg_txsrc_type;

  // transmit-side pins, bit positions match the transmit invert register
  typedef struct packed {
    logic pdat_en_out;
    logic pdat;
    logic unused13;
    logic sof_den_out;
    logic poh_en_in;
    logic ser_in;
    logic oh_sof;
    logic oh_en;
    logic oh;
    logic oh_clk;
    logic sof_in;
    logic neg_out;
    logic pos_out;
    logic line_clk;
    logic clk_out;
    logic clk_in;
  } pcfg_txpins_type;

  // receive-side pins, bit positions match the receive invert register
  typedef struct packed {
    logic unused15;
    logic pdat;
    logic fohen_in;
    logic sof_den_out;
    logic unused11;
    logic ser_out;
    logic oh_sof;
    logic unused8;
    logic oh;
    logic oh_clk;
    logic unused5;
    logic neg_in;
    logic pos_in;
    logic line_clk;
    logic clk_out;
    logic unused0;
  } pcfg_rxpins_type;

endpackage

// ---- logic/pcfg_invert.sv ----
// polarity inverter between pins and core logic
`timescale 1ns/1ps
`default_nettype none
module pcfg_invert #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] mask,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  initial begin
    if (WIDTH < 1) $error("pcfg_invert: width must be positive");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // pure xor, no flop: inversion sits right at the pin
      assign dout[i] = din[i] ^ mask[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verif/pcfg_checker.sv ----
// assertion checker for the port configuration block
`timescale 1ns/1ps
`default_nettype none
module pcfg_checker
  import pcfg_pkg::*;
#(
  parameter int ALARM_COUNT = 16
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic RX_FRAC_PORT_EN,
  input wire logic TX_FRAC_PORT_EN,
  input wire logic [3:0] LOCAL_REF_8K,
  input wire logic GLOBAL_REF_8K,
  input wire logic PORT_REF_8K,
  input wire logic TIMER_REF_8K,
  input wire logic [3:0] TX_CLOCK_SRC,
  input wire logic SYS_LOOPBACK_EN,
  input wire logic [2:0] LOOPBACK_MODE,
  input wire logic LOOPBACK_ACTIVE,
  input wire logic [ALARM_COUNT-1:0] ALARM_STATUS,
  input wire logic GPIO_A_OUT_EN,
  input wire logic GPIO_B_OUT_EN,
  input wire logic GPIO_A_OUT,
  input wire logic GPIO_B_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic wr;
  logic any_alarm;
  // byte addresses on the bus are four times the register index
  localparam logic [11:0] CTRL_ADDR = {PCFG_OFS_CTRL[9:0], 2'b00};
  localparam logic [11:0] LOOP_ADDR = {PCFG_OFS_LOOP[9:0], 2'b00};
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign any_alarm = |ALARM_STATUS;
  ////////////////////////////////////////////////////////////////////////////////
  AST_LB_ACTIVE: assert property (LOOPBACK_ACTIVE == (LOOPBACK_MODE != PCFG_LBM_NONE || SYS_LOOPBACK_EN))
    else $error("loopback active flag wrong");
  AST_RESET_STATE: assert property ($rose(RESETN) |-> !RX_FRAC_PORT_EN && !TX_FRAC_PORT_EN &&
    LOOPBACK_MODE == PCFG_LBM_NONE && !SYS_LOOPBACK_EN) else $error("state not cleared by reset");
  AST_REF_RESET: assert property ($rose(RESETN) |-> PORT_REF_8K == LOCAL_REF_8K[0] &&
    TIMER_REF_8K == GLOBAL_REF_8K) else $error("reference select wrong after reset");
  AST_CTRL_WRITE: assert property (wr && PADDR == CTRL_ADDR |=>
    RX_FRAC_PORT_EN == $past(PWDATA[11]) && TX_FRAC_PORT_EN == $past(PWDATA[8])) else $error("port enables off");
  AST_LOOP_WRITE: assert property (wr && PADDR == LOOP_ADDR |=>
    LOOPBACK_MODE == $past(PWDATA[10:8]) && SYS_LOOPBACK_EN == $past(PWDATA[11])) else $error("loop fields off");
  AST_LOOP_HOLD: assert property (!(wr && PADDR == LOOP_ADDR) |=>
    $stable(LOOPBACK_MODE) && $stable(SYS_LOOPBACK_EN)) else $error("loop fields moved without write");
  AST_GPIO_A: assert property (GPIO_A_OUT |-> $past(GPIO_A_OUT_EN) && $past(any_alarm))
    else $error("first alarm pin high without cause");
  AST_GPIO_B: assert property (GPIO_B_OUT |-> $past(GPIO_B_OUT_EN) && $past(any_alarm))
    else $error("second alarm pin high without cause");
  AST_TXSRC_LOOP: assert property (LOOPBACK_MODE != PCFG_LBM_NONE |->
    TX_CLOCK_SRC inside {PCFG_TXS_LINE, PCFG_TXS_RECOV}) else $error("loopback not on receive clock");
  AST_TXSRC_ONEHOT: assert property ($onehot(TX_CLOCK_SRC))
    else $error("tx clock source not one-hot");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (wr && PADDR == CTRL_ADDR);
  cover property (GPIO_A_OUT && GPIO_B_OUT);
  cover property (LOOPBACK_MODE != PCFG_LBM_NONE && SYS_LOOPBACK_EN);
endmodule
bind pcfg_top pcfg_checker #(.ALARM_COUNT(ALARM_COUNT)) u_chk (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .RX_FRAC_PORT_EN(RX_FRAC_PORT_EN), .TX_FRAC_PORT_EN(TX_FRAC_PORT_EN), .LOCAL_REF_8K(LOCAL_REF_8K),
  .GLOBAL_REF_8K(GLOBAL_REF_8K), .PORT_REF_8K(PORT_REF_8K), .TIMER_REF_8K(TIMER_REF_8K),
  .TX_CLOCK_SRC(TX_CLOCK_SRC), .SYS_LOOPBACK_EN(SYS_LOOPBACK_EN), .LOOPBACK_MODE(LOOPBACK_MODE),
  .LOOPBACK_ACTIVE(LOOPBACK_ACTIVE), .ALARM_STATUS(ALARM_STATUS), .GPIO_A_OUT_EN(GPIO_A_OUT_EN),
  .GPIO_B_OUT_EN(GPIO_B_OUT_EN), .GPIO_A_OUT(GPIO_A_OUT), .GPIO_B_OUT(GPIO_B_OUT));
`default_nettype wire

// ---- verif/test_port_io_clock_loopback_config.sv ----
// self-checking bench for the port configuration block
`timescale 1ns/1ps
`default_nettype none
module test_port_io_clock_loopback_config
  import pcfg_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic [15:0] w; logic [15:0] r; logic err;} pcfg_row_type;
  pcfg_row_type rows [9] = '{'{PCFG_OFS_CTRL, 16'hffff, 16'h3fff, 1'b0}, '{PCFG_OFS_LOOP, 16'hffff, 16'h0fff, 1'b0},
    '{PCFG_OFS_TINV, 16'hffff, 16'hdfff, 1'b0}, '{PCFG_OFS_RINV, 16'hffff, 16'h76de, 1'b0},
    '{12'h048, 16'hffff, 16'h0000, 1'b1}, '{PCFG_OFS_STAT, 16'h001f, 16'h0000, 1'b1},
    '{PCFG_OFS_CTRL, 16'hc000, 16'h0000, 1'b0}, '{PCFG_OFS_RINV, 16'h8921, 16'h0000, 1'b0},
    '{PCFG_OFS_LOOP, 16'hf000, 16'h0000, 1'b0}};
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e, a_en, b_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] c, alarm, w, v;
  logic [3:0] lref, n, s4, src;
  logic [2:0] loopback_mode_select;
  pcfg_txpins_type tcore, tpin, tpo, tci;
  pcfg_rxpins_type rcore, rpin, rpo, rci;
  logic rfe, tfe, pref, tref, tclk, rft, tft, tlt, system_bus_loopback, lba, ga, gb, pr, ck;
  int errors, total_checks;
  int cyc = 0;
  pcfg_top dut (.MCLK(mclk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_CORE(tcore), .TX_PIN_IN(tpin),
    .TX_PIN_OUT(tpo), .TX_CORE_IN(tci), .RX_CORE(rcore), .RX_PIN_IN(rpin), .RX_PIN_OUT(rpo), .RX_CORE_IN(rci),
    .RX_RECOV_OUT_CLK(c[0]), .RX_GAPPED_CLK(c[1]), .RX_OVERHEAD_CLK(c[2]), .RX_OVERHEAD_MODE(c[3]),
    .TX_OUT_CLK(c[4]), .TX_GAPPED_CLK(c[5]), .TX_OVERHEAD_CLK(c[6]), .TX_OVERHEAD_MODE(c[7]), .RX_SOF(c[8]),
    .RX_DEN(c[9]), .TX_SOF(c[10]), .TX_DEN(c[11]), .LIU_RECOV_CLK(c[12]), .CLOCK_RATE_ADAPTER_CLK(c[13]),
    .LIU_ENABLED(c[14]), .GLOBAL_REF_8K(c[15]), .LOCAL_REF_8K(lref), .ALARM_STATUS(alarm),
    .GPIO_A_OUT_EN(a_en), .GPIO_B_OUT_EN(b_en), .RX_FRAC_PORT_EN(rfe), .TX_FRAC_PORT_EN(tfe),
    .PORT_REF_8K(pref), .TIMER_REF_8K(tref), .TX_CLOCK_INT(tclk), .TX_CLOCK_SRC(src),
    .RX_FRAMER_INPUT_TIMED(rft), .TX_FRAMER_INPUT_TIMED(tft), .TX_LINE_INPUT_TIMED(tlt),
    .SYS_LOOPBACK_EN(system_bus_loopback), .LOOPBACK_MODE(loopback_mode_select), .LOOPBACK_ACTIVE(lba), .GPIO_A_OUT(ga), .GPIO_B_OUT(gb));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // holds the request until ready is seen at a rising edge, then releases on that edge
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {a[9:0], 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n, a_en, b_en} = '0;
    {c, lref, alarm, tcore, tpin, rcore, rpin} = '0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[j]) begin
      apb(rows[j].a, 1'b1, {16'hffff, rows[j].w});
      chk(e, rows[j].err);
      if (rows[j].a != PCFG_OFS_STAT) begin
        apb(rows[j].a, 1'b0, 32'h0);
        chk(q, {16'h0, rows[j].r});
        chk(e, rows[j].err);
      end
    end
    // polarity both ways, ends with inversion off
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      v = i ? 16'h0000 : 16'hffff;
      tcore <= 16'h3a5c ^ v;
      tpin <= 16'hc6b1 ^ v;
      rcore <= 16'h5e27 ^ v;
      rpin <= 16'hb3d8 ^ v;
      apb(PCFG_OFS_CTRL, 1'b1, 32'h0100);
      apb(PCFG_OFS_TINV, 1'b1, {16'h0, v});
      apb(PCFG_OFS_RINV, 1'b1, {16'h0, v});
      @(negedge mclk);
      chk(tci & 16'hdfff, (tpin ^ v) & 16'hdfff);
      chk(rci & 16'h76de, (rpin ^ v) & 16'h76de);
      chk(tpo & 16'h0ffd, (tcore ^ v) & 16'h0ffd);
      chk(rpo & 16'h06c0, (rcore ^ v) & 16'h06c0);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      n = i[3:0];
      c <= {4{n}} ^ 16'h3c5a;
      lref <= ~n;
      tpin <= {4{~n}};
      rpin <= {4{n}} ^ 16'h0f0f;
      w = {2'b0, n[3], n[2], n[0], n[1], n[2] ^ n[3], ~n[0], n[1:0], n[3], n[0] ^ n[3], n[1], n[2:0]};
      apb(PCFG_OFS_CTRL, 1'b1, {16'h0, w});
      @(negedge mclk);
      pr = lref[w[7:6]];
      s4 = w[4] ? (c[14] ? 4'h8 : 4'h2) : w[3] ? 4'h1 : 4'h4;
      ck = s4[3] ? c[12] : s4[1] ? rpin.line_clk : s4[2] ? c[13] : tpin.clk_in;
      chk(rpo.clk_out, w[13] ? c[0] : w[11] ? c[1] : c[3] & c[2]);
      chk(rpo.sof_den_out, w[12] ? c[8] : c[9]);
      chk(tpo.clk_out, w[10] ? c[4] : c[7] ? c[6] : c[5]);
      chk(tpo.sof_den_out, w[9] ? c[10] : c[11]);
      chk({rfe, tfe, rft, tft, tlt}, {w[11], w[8], w[2:0]});
      chk({pref, tref}, {pr, w[5] ? pr : c[15]});
      chk({src, tclk}, {s4, ck});
      chk({tci.pdat, rpo.pdat, tpo.pdat_en_out}, {w[8] & tpin.pdat, w[11] & rcore.pdat, w[8] & tcore.pdat_en_out});
    end
    // last control word leaves loop timing off and the adapter excluded
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk);
      n = k[3:0];
      c[14] <= n[0];
      apb(PCFG_OFS_LOOP, 1'b1, {20'h0, n, 8'h0});
      @(negedge mclk);
      chk({system_bus_loopback, loopback_mode_select, lba}, {n, n != 4'h0});
      chk(src, n[2:0] != 3'h0 ? (n[0] ? 4'h8 : 4'h2) : 4'h1);
    end
    // status word: loopback active, recovered clock chosen
    apb(PCFG_OFS_STAT, 1'b0, 32'h0);
    chk(q, 32'h0000_0018);
    chk(e, 1'b0);
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk);
      n = k[3:0];
      alarm <= 16'h9b35 ^ {4{n}};
      a_en <= n[0];
      b_en <= n[1];
      apb(PCFG_OFS_LOOP, 1'b1, {24'h0, ~n, n});
      @(posedge mclk);
      @(negedge mclk);
      chk({ga, gb}, {a_en & alarm[n], b_en & alarm[~n]});
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      apb(rows[j].a, 1'b0, 32'h0);
      chk(q, 32'h0);
    end
    chk({loopback_mode_select, system_bus_loopback, lba, rfe, tfe, ga, gb}, 9'h0);
    close_out();
  end
endmodule
`default_nettype wire
